// *** verilog/apc_map.svh ***
// Register offsets, field positions, reset values and source codes for the pin configuration block
`ifndef APC_MAP_SVH
`define APC_MAP_SVH

`define APC_PIN_ONE_CONFIG_OFS 8'h03
`define APC_PIN_TWO_CONFIG_OFS 8'h04

`define APC_SRC_HI 7
`define APC_SRC_LO 4
`define APC_PULL_HI 3
`define APC_PULL_LO 2
`define APC_IBUF_BIT 1
`define APC_DRV_BIT 0

`define APC_PIN_ONE_RESET 8'h05
`define APC_PIN_TWO_RESET 8'h04

`define APC_P1_SRC_POR 4'h0
`define APC_P1_SRC_SW 4'h1
`define APC_P1_SRC_PLL 4'h2
`define APC_P1_SRC_LOS_FIRST 4'h4
`define APC_P1_SRC_LOS_LAST 4'h8
`define APC_P2_SRC_SW 4'h0
`define APC_P2_SRC_ON 4'h1

`define APC_PULL_NONE 2'h0
`define APC_PULL_DOWN 2'h1
`define APC_PULL_UP 2'h2

`define APC_UNMAPPED_READ 8'h00

`endif

// *** verilog/apc_pkg.sv ***
// Types for the pin configuration block
package apc_pkg;

	typedef struct packed {
		logic [7:0] cfg_one;
		logic [7:0] cfg_two;
		logic [7:0] rdata;
		logic rvalid;
		logic p1_out;
		logic p1_drive_en;
		logic p1_pull_up;
		logic p1_pull_down;
		logic p1_in_buf_en;
		logic p2_out;
		logic p2_drive_en;
	} apc_state_type;

endpackage

// *** verilog/apc_pin_config.sv ***
// Configuration logic for auxiliary pins one and two
`timescale 1ns/1ns
`include "apc_map.svh"

// Overview of operation
// - Pin one source select bits 7:4, reset 0000; POR, software, PLL lock, lane losses.
// - Pin one pull control bits 3:2, reset 01; none, pulldown, pullup, 11 reserved.
// - Pin one bit 1 enables the input buffer; resets to 0.
// - Pin one bit 0 enables the output driver; resets to 1, else high impedance.
// - Pin two source select bits 7:4, reset 0000; software value or constant active.
module apc_pin_config #(
	parameter int LANES = 5
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rdata_valid,
	input wire logic por_active,
	input wire logic pll_lock,
	input wire logic [LANES-1:0] lane_signal_loss,
	input wire logic sw_output_value,
	output logic pin_one_out,
	output logic pin_one_drive_en,
	output logic pin_one_pull_up,
	output logic pin_one_pull_down,
	output logic pin_one_in_buf_en,
	output logic pin_two_out,
	output logic pin_two_drive_en
);
	import apc_pkg::*;

	apc_state_type state;
	apc_state_type next_state;
	logic [3:0] src_one;
	logic [3:0] src_two;
	logic [1:0] pull_one;

	assign src_one = state.cfg_one[`APC_SRC_HI:`APC_SRC_LO];
	assign src_two = state.cfg_two[`APC_SRC_HI:`APC_SRC_LO];
	assign pull_one = state.cfg_one[`APC_PULL_HI:`APC_PULL_LO];

	always_comb begin
		next_state = state;
		next_state.rvalid = 1'b0;
		// Register writes
		if (reg_wr && reg_addr == `APC_PIN_ONE_CONFIG_OFS) begin
			next_state.cfg_one = reg_wdata;
		end
		if (reg_wr && reg_addr == `APC_PIN_TWO_CONFIG_OFS) begin
			next_state.cfg_two = reg_wdata;
		end
		// Register reads
		if (reg_rd) begin
			next_state.rvalid = 1'b1;
			case (reg_addr)
				`APC_PIN_ONE_CONFIG_OFS: begin
					next_state.rdata = state.cfg_one;
				end
				`APC_PIN_TWO_CONFIG_OFS: begin
					next_state.rdata = state.cfg_two;
				end
				default: begin
					next_state.rdata = `APC_UNMAPPED_READ;
				end
			endcase
		end
		// Pin one source
		case (src_one)
			`APC_P1_SRC_POR: begin
				next_state.p1_out = por_active;
			end
			`APC_P1_SRC_SW: begin
				next_state.p1_out = sw_output_value;
			end
			`APC_P1_SRC_PLL: begin
				next_state.p1_out = pll_lock;
			end
			default: begin
				if (src_one >= `APC_P1_SRC_LOS_FIRST && src_one <= `APC_P1_SRC_LOS_LAST) begin
					next_state.p1_out = lane_signal_loss[3'(src_one - `APC_P1_SRC_LOS_FIRST)];
				end else begin
					next_state.p1_out = 1'b0;
				end
			end
		endcase
		// Pin one pad controls
		next_state.p1_pull_down = (pull_one == `APC_PULL_DOWN);
		next_state.p1_pull_up = (pull_one == `APC_PULL_UP);
		next_state.p1_in_buf_en = state.cfg_one[`APC_IBUF_BIT];
		next_state.p1_drive_en = state.cfg_one[`APC_DRV_BIT];
		// Pin two source
		case (src_two)
			`APC_P2_SRC_SW: begin
				next_state.p2_out = sw_output_value;
			end
			`APC_P2_SRC_ON: begin
				next_state.p2_out = 1'b1;
			end
			default: begin
				next_state.p2_out = 1'b0;
			end
		endcase
		next_state.p2_drive_en = state.cfg_two[`APC_DRV_BIT];
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state <= '0;
			state.cfg_one <= `APC_PIN_ONE_RESET;
			state.cfg_two <= `APC_PIN_TWO_RESET;
			state.p1_drive_en <= 1'b1;
			state.p1_pull_down <= 1'b1;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	assign reg_rdata = state.rdata;
	assign reg_rdata_valid = state.rvalid;
	assign pin_one_out = state.p1_out;
	assign pin_one_drive_en = state.p1_drive_en;
	assign pin_one_pull_up = state.p1_pull_up;
	assign pin_one_pull_down = state.p1_pull_down;
	assign pin_one_in_buf_en = state.p1_in_buf_en;
	assign pin_two_out = state.p2_out;
	assign pin_two_drive_en = state.p2_drive_en;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	// Register port
	a_cfg_one_write: assert property (clk_en && reg_wr && reg_addr == `APC_PIN_ONE_CONFIG_OFS
		|=> state.cfg_one == $past(reg_wdata))
		else $error("pin one config not written");
	a_cfg_two_write: assert property (clk_en && reg_wr && reg_addr == `APC_PIN_TWO_CONFIG_OFS
		|=> state.cfg_two == $past(reg_wdata))
		else $error("pin two config not written");
	a_write_refused: assert property (clk_en && reg_wr && reg_addr != `APC_PIN_ONE_CONFIG_OFS
		&& reg_addr != `APC_PIN_TWO_CONFIG_OFS |=> $stable(state.cfg_one) && $stable(state.cfg_two))
		else $error("write to unmapped offset landed");
	a_cfg_one_readback: assert property (clk_en && reg_rd && reg_addr == `APC_PIN_ONE_CONFIG_OFS
		|=> reg_rdata_valid && reg_rdata == $past(state.cfg_one))
		else $error("pin one readback wrong");
	a_cfg_two_readback: assert property (clk_en && reg_rd && reg_addr == `APC_PIN_TWO_CONFIG_OFS
		|=> reg_rdata_valid && reg_rdata == $past(state.cfg_two))
		else $error("pin two readback wrong");
	a_unmapped_read: assert property (clk_en && reg_rd && reg_addr != `APC_PIN_ONE_CONFIG_OFS
		&& reg_addr != `APC_PIN_TWO_CONFIG_OFS |=> reg_rdata_valid && reg_rdata == `APC_UNMAPPED_READ)
		else $error("unmapped read not zero");
	a_valid_pulse: assert property (clk_en && !reg_rd |=> !reg_rdata_valid)
		else $error("read valid without read");
	a_rdata_hold: assert property (clk_en && !reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	a_reset_values: assert property ($rose(rst_b) |-> state.cfg_one == `APC_PIN_ONE_RESET
		&& state.cfg_two == `APC_PIN_TWO_RESET && pin_one_drive_en && pin_one_pull_down && !pin_one_in_buf_en)
		else $error("reset configuration wrong");

	// Pin one
	a_por_source: assert property (clk_en && src_one == `APC_P1_SRC_POR |=> pin_one_out == $past(por_active))
		else $error("power on indicator not routed");
	a_sw_source: assert property (clk_en && src_one == `APC_P1_SRC_SW |=> pin_one_out == $past(sw_output_value))
		else $error("software value not routed");
	a_pll_source: assert property (clk_en && src_one == `APC_P1_SRC_PLL |=> pin_one_out == $past(pll_lock))
		else $error("pll lock not routed");
	a_lane_source: assert property (clk_en && src_one == 4'h6 |=> pin_one_out == $past(lane_signal_loss[2]))
		else $error("lane loss not routed");
	a_pull_select: assert property (clk_en |=> pin_one_pull_up == ($past(pull_one) == `APC_PULL_UP)
		&& pin_one_pull_down == ($past(pull_one) == `APC_PULL_DOWN))
		else $error("pull select wrong");
	a_pull_reserved: assert property (clk_en && pull_one == 2'h3
		|=> !pin_one_pull_up && !pin_one_pull_down)
		else $error("reserved pull code enables a resistor");
	a_pull_write: assert property (clk_en && reg_wr && reg_addr == `APC_PIN_ONE_CONFIG_OFS ##1 clk_en
		|=> pin_one_pull_up == ($past(reg_wdata[`APC_PULL_HI:`APC_PULL_LO], 2) == `APC_PULL_UP)
		&& pin_one_pull_down == ($past(reg_wdata[`APC_PULL_HI:`APC_PULL_LO], 2) == `APC_PULL_DOWN))
		else $error("pull select lags write");
	a_ibuf_follow: assert property (clk_en |=> pin_one_in_buf_en == $past(state.cfg_one[`APC_IBUF_BIT]))
		else $error("input buffer enable wrong");
	a_ibuf_write: assert property (clk_en && reg_wr && reg_addr == `APC_PIN_ONE_CONFIG_OFS ##1 clk_en
		|=> pin_one_in_buf_en == $past(reg_wdata[`APC_IBUF_BIT], 2))
		else $error("input buffer enable lags write");
	a_drive_follow: assert property (clk_en |=> pin_one_drive_en == $past(state.cfg_one[`APC_DRV_BIT]))
		else $error("drive enable wrong");
	a_drive_write: assert property (clk_en && reg_wr && reg_addr == `APC_PIN_ONE_CONFIG_OFS ##1 clk_en
		|=> pin_one_drive_en == $past(reg_wdata[0], 2))
		else $error("drive enable lags write");
	a_reserved_quiet: assert property (clk_en && (src_one == 4'h3 || src_one > 4'h8) |=> !pin_one_out)
		else $error("reserved code drives pin one");
	// One routing check per lane
	for (genvar g = 0; g < LANES; g++) begin : g_lane_route
		a_lane_route: assert property (@(posedge clk_sys) disable iff (!rst_b)
			clk_en && src_one == 4'(`APC_P1_SRC_LOS_FIRST + g) |=> pin_one_out == $past(lane_signal_loss[g]))
			else $error("lane loss not routed to pin one");
	end

	// Pin two
	a_two_software: assert property (clk_en && src_two == `APC_P2_SRC_SW
		|=> pin_two_out == $past(sw_output_value))
		else $error("pin two software value not routed");
	a_two_constant: assert property (clk_en && src_two == `APC_P2_SRC_ON |=> pin_two_out)
		else $error("pin two not constant active");
	a_two_reserved: assert property (clk_en && src_two > `APC_P2_SRC_ON |=> !pin_two_out)
		else $error("reserved code drives pin two");
	a_two_drive: assert property (clk_en |=> pin_two_drive_en == $past(state.cfg_two[`APC_DRV_BIT]))
		else $error("pin two drive enable wrong");

	// Clock enable
	a_freeze_hold: assert property (!clk_en |=> $stable(state))
		else $error("state moved while frozen");
	a_freeze_outputs: assert property (!clk_en |=> $stable(pin_one_out) && $stable(pin_two_out))
		else $error("pin output moved while frozen");

	// Scenario coverage
	c_los_lane_four: cover property (clk_en && src_one == `APC_P1_SRC_LOS_LAST && lane_signal_loss[4] ##1 pin_one_out);
	c_input_mode: cover property (clk_en && reg_wr && reg_addr == `APC_PIN_ONE_CONFIG_OFS && reg_wdata[1:0] == 2'h2);
	c_pin_two_sw: cover property (clk_en && src_two == `APC_P2_SRC_SW && sw_output_value ##1 pin_two_out);
	c_unmapped_read: cover property (clk_en && reg_rd && reg_addr != `APC_PIN_ONE_CONFIG_OFS
		&& reg_addr != `APC_PIN_TWO_CONFIG_OFS);
	c_freeze_resume: cover property (!clk_en ##1 clk_en);
endmodule

// *** tb/apc_board.sv ***
// Board-side model of pin one's wire with its resistors
`timescale 1ns/1ns
module apc_board (
	input wire logic clk_sys,
	input wire logic drive_en,
	input wire logic out,
	input wire logic pull_up,
	input wire logic pull_down,
	output logic level
);
	always_ff @(posedge clk_sys) begin
		if (drive_en) begin
			level <= out;
		end else if (pull_up) begin
			level <= 1'b1;
		end else if (pull_down) begin
			level <= 1'b0;
		end else begin
			level <= ~level;
		end
	end
endmodule

// *** tb/aux_pin_config_one_two_tb.sv ***
// Self-checking bench for the pin configuration block
`timescale 1ns/1ns
module aux_pin_config_one_two_tb;
	logic clk_sys = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, por = 0, pll = 0, sw = 0, en = 1, lvl, rsv;
	logic [7:0] addr = 0, wdata = 0, rdata;
	logic rv, o1, d1, pu, pd, ib, o2, d2;
	logic [4:0] los = 0;
	int n_fail = 0, comparisons = 0;
	apc_pin_config i_apc_pin_config (.clk_sys, .rst_b, .clk_en(en), .reg_addr(addr), .reg_wr, .reg_wdata(wdata),
		.reg_rd, .reg_rdata(rdata), .reg_rdata_valid(rv), .por_active(por), .pll_lock(pll), .lane_signal_loss(los),
		.sw_output_value(sw), .pin_one_out(o1), .pin_one_drive_en(d1), .pin_one_pull_up(pu), .pin_one_pull_down(pd),
		.pin_one_in_buf_en(ib), .pin_two_out(o2), .pin_two_drive_en(d2));
	apc_board i_apc_board (.clk_sys, .drive_en(d1), .out(o1), .pull_up(pu), .pull_down(pd), .level(lvl));
	initial begin
		forever #4 clk_sys = ~clk_sys;
	end
	task chk(string n, logic [7:0] e, logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task step(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task wr(logic [7:0] a, logic [7:0] d);
		addr = a;
		wdata = d;
		reg_wr = 1;
		step(1);
		reg_wr = 0;
	endtask
	task rd(logic [7:0] a, logic [7:0] e);
		addr = a;
		reg_rd = 1;
		step(1);
		chk("valid", 8'h1, rv);
		chk("rdata", e, rdata);
		reg_rd = 0;
		step(1);
	endtask
	task wrap_up;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#20000;
		n_fail++;
		$display("ERROR watchdog expected done seen timeout");
		wrap_up;
	end
	initial begin
		step(12);
		rst_b = 1;
		rd(8'h03, 8'h05);
		rd(8'h04, 8'h04);
		rd(8'h10, 8'h00);
		chk("drive", 8'h1, d1);
		chk("pull down", 8'h1, pd);
		chk("in buf", 8'h0, ib);
		$display("test reset done");
		for (int c = 0; c < 16; c++) begin
			rsv = !(c inside {[0:2], [4:8]});
			por = rsv || c == 0;
			sw = rsv || c == 1;
			pll = rsv || c == 2;
			for (int i = 0; i < 5; i++) los[i] = rsv || c == 4 + i;
			wr(8'h03, {c[3:0], 4'h5});
			step(2);
			chk("pin1 out", !rsv, o1);
			chk("board", !rsv, lvl);
		end
		rd(8'h03, 8'hf5);
		$display("test pin one source done");
		for (int p = 0; p < 4; p++) begin
			wr(8'h03, {4'h1, p[1:0], 2'b10});
			step(2);
			chk("pull up", p == 2, pu);
			chk("pull down", p == 1, pd);
			chk("buf drive", 8'h2, {ib, d1});
			if (p == 1 || p == 2) chk("board", p == 2, lvl);
		end
		$display("test pull done");
		for (int c = 0; c < 3; c++) begin
			sw = c != 1;
			wr(8'h04, {c[3:0], 4'h5});
			step(1);
			chk("pin2 out", c < 2, o2);
			chk("pin2 drive", 8'h1, d2);
		end
		$display("test pin two done");
		wr(8'h04, 8'h05);
		step(1);
		en = 0;
		sw = 0;
		wr(8'h04, 8'h15);
		step(2);
		chk("frozen pin2", 8'h1, o2);
		en = 1;
		rd(8'h04, 8'h05);
		chk("thawed pin2", 8'h0, o2);
		$display("test freeze done");
		wrap_up;
	end
endmodule
